/* hw/rse_status_encoder.v */
// Receive descriptor status encoder with its APB register file.
// Assumes the receive path offers one data unit event at a time, each
// with its flags, and that the descriptor writer takes one descriptor
// word with valid/ready. Everything runs on i_clk.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps
`include "rse_consts.vh"
module rse_status_encoder
#(
  parameter CNT_W = 16,   // Width of per-class counters
  parameter THR_W = 8     // Width of the copied-frame threshold
)
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_arst_n,
  // APB
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  // Data unit events from the receive path
  input  wire        i_unit_valid,
  output wire        o_unit_ready,
  input  wire        i_frame_end,
  input  wire        i_page_cross,
  input  wire        i_header_end,
  input  wire        i_queue_last,
  // Copy abort causes
  input  wire        i_no_data_space,
  input  wire        i_no_hdr_space,
  input  wire        i_no_info_space,
  input  wire        i_info_copied,
  // Frame errors
  input  wire        i_fifo_overrun,
  input  wire        i_bad_frame,
  input  wire        i_parity_err,
  input  wire        i_hw_fault,
  // Breakpoint events, one-cycle pulses
  input  wire        i_burst_evt,
  input  wire        i_token_evt,
  input  wire        i_mac_reset_event,
  input  wire        i_mac_frame_evt,
  input  wire        i_ringop_evt,
  // Descriptor write
  output wire        o_desc_valid,
  input  wire        i_desc_ready,
  output wire [3:0]  o_desc_status,
  output wire [1:0]  o_desc_fl
);

  ////////////////////////////////////////////////////////////////////////
  // Frame tracking states
  localparam [1:0] ST_IDLE    = 2'b00;  // Next unit opens a frame
  localparam [1:0] ST_FRAME   = 2'b01;  // Inside a frame
  localparam [1:0] ST_DISCARD = 2'b10;  // Dropping rest of a frame

  reg  [1:0]       state_reg;       // Frame tracking state
  reg  [1:0]       state_next;
  reg  [2:0]       ctrl_reg;        // Enable, sort mode, flow bit
  reg  [THR_W-1:0] thresh_reg;      // Copied-frame limit, 0 = off
  reg  [THR_W-1:0] fcnt_reg;        // Normal-end frames since hit
  reg  [THR_W-1:0] fcnt_next;
  reg              burst_pend_reg;  // Burst boundary seen
  reg              svc_pend_reg;    // Service opportunity seen
  reg              fault_reg;       // Sticky internal fault
  reg              dvalid_reg;      // Descriptor pending
  reg  [3:0]       status_reg;      // Status of pending descriptor
  reg  [1:0]       fl_reg;          // Tag of pending descriptor
  reg  [3:0]       last_st_reg;     // Last status handed over
  reg  [1:0]       last_fl_reg;     // Last tag handed over
  reg  [3:0]       code;            // Status for the offered unit
  reg  [1:0]       tag;             // Tag for the offered unit
  reg              ends;            // Unit closes the descriptor chain
  reg              norm_end;        // Unit is a normal frame end
  reg              cause_bad;       // Non-end unit with no cause

  wire             en_w;            // Block enabled
  wire             sort_w;          // Header/info sort mode
  wire             flow_w;          // Parity flow-through bit
  wire             accept;          // Unit taken this cycle
  wire             emit;            // Accepted unit yields a descriptor
  wire             handed;          // Descriptor taken by the writer
  wire             first_unit;      // Unit opens a frame
  wire             svc_evt;         // Any service opportunity event
  wire             bad_state;       // Illegal tracking state
  wire             fault_now;       // Fault to report on this unit
  wire             thr_hit;         // Threshold reached by this frame
  wire             wr_stb;          // APB write strobe
  wire             hit;             // Address decodes
  reg  [31:0]      rdata;           // Read mux
  wire [CNT_W-1:0] cnt [0:3];       // Per-class counts

  assign en_w   = ctrl_reg[`RSE_CTRL_EN];
  assign sort_w = ctrl_reg[`RSE_CTRL_SORT];
  assign flow_w = ctrl_reg[`RSE_CTRL_FLOW];

  ////////////////////////////////////////////////////////////////////////
  // Handshakes: one slot of output, refilled in the cycle it drains
  assign o_unit_ready = en_w & (~dvalid_reg | i_desc_ready);
  assign accept       = i_unit_valid & o_unit_ready;
  assign emit         = accept & (state_reg != ST_DISCARD);
  assign handed       = dvalid_reg & i_desc_ready;
  assign first_unit   = (state_reg == ST_IDLE);
  assign svc_evt      = i_token_evt | i_mac_reset_event |
                        i_mac_frame_evt | i_ringop_evt;
  assign bad_state    = (state_reg == 2'b11);
  assign fault_now    = fault_reg | i_hw_fault | bad_state;

  // Threshold counts normal-end frames, hits on the limit itself
  assign thr_hit = (thresh_reg != {THR_W{1'b0}}) &&
                   (fcnt_reg + {{(THR_W-1){1'b0}}, 1'b1} == thresh_reg);

  ////////////////////////////////////////////////////////////////////////
  // Status code selection; errors outrank aborts, aborts outrank
  // breakpoints so the host never keeps a damaged frame
  always @*
  begin
    code      = `RSE_IS_NORM;
    ends      = i_frame_end;
    norm_end  = 1'b0;
    cause_bad = 1'b0;
    if (fault_now)
    begin
      code = `RSE_IS_INTERNAL;
      ends = 1'b1;
    end
    else if (!i_frame_end)
    begin
      if (i_page_cross && i_queue_last)
      begin
        code = `RSE_IS_LAST_PC;
        ends = 1'b1;
      end
      else if (i_page_cross && i_header_end)
        code = `RSE_IS_PC_HDR;
      else if (i_page_cross)
        code = `RSE_IS_PC;
      else if (i_header_end)
        code = `RSE_IS_HDR;
      else
      begin
        // A non-end unit without cause means the path is broken
        code      = `RSE_IS_INTERNAL;
        ends      = 1'b1;
        cause_bad = 1'b1;
      end
    end
    else if (i_parity_err && flow_w)
      code = `RSE_IS_PARITY;
    else if (i_bad_frame)
      code = `RSE_IS_BAD_FRAME;
    else if (i_fifo_overrun)
      code = `RSE_IS_OVERRUN;
    else if (sort_w && i_no_hdr_space)
      code = `RSE_IS_NO_HDR;
    else if (sort_w && i_no_info_space && !i_info_copied)
      code = `RSE_IS_NO_INFO;
    else if (sort_w && i_no_info_space)
      code = `RSE_IS_PART_INFO;
    else if (!sort_w && i_no_data_space)
      code = `RSE_IS_NO_DATA;
    else
    begin
      norm_end = 1'b1;
      if (svc_pend_reg || svc_evt)
        code = `RSE_IS_SVC;
      else if (thr_hit)
        code = `RSE_IS_THRESH;
      else if (burst_pend_reg || i_burst_evt)
        code = `RSE_IS_BURST;
      else
        code = `RSE_IS_NORM;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Part tag from frame position; a chain-ending unit is never middle
  always @*
  begin
    case ({first_unit, ends})
      2'b10:   tag = `RSE_FL_FIRST;
      2'b11:   tag = `RSE_FL_ONLY;
      2'b01:   tag = `RSE_FL_LAST;
      default: tag = `RSE_FL_MIDDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame tracking; rest of a frame cut short is consumed silently
  always @*
  begin
    state_next = state_reg;
    if (accept)
    begin
      case (state_reg)
        ST_IDLE,
        ST_FRAME:
          if (i_frame_end)
            state_next = ST_IDLE;
          else if (ends)
            state_next = ST_DISCARD;
          else
            state_next = ST_FRAME;
        ST_DISCARD:
          if (i_frame_end)
            state_next = ST_IDLE;
        default:
          state_next = ST_IDLE;
      endcase
    end
    else if (bad_state)
      state_next = ST_IDLE;
  end

  // Threshold count restarts on each hit
  always @*
  begin
    fcnt_next = fcnt_reg;
    if (emit && norm_end && !fault_now)
    begin
      if (thr_hit)
        fcnt_next = {THR_W{1'b0}};
      else
        fcnt_next = fcnt_reg + {{(THR_W-1){1'b0}}, 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Descriptor slot: status and tag leave together in one word
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dvalid_reg <= 1'b0;
      status_reg <= 4'h0;
      fl_reg     <= 2'h0;
    end
    else if (emit)
    begin
      dvalid_reg <= 1'b1;
      status_reg <= code;
      fl_reg     <= tag;
    end
    else if (handed)
      dvalid_reg <= 1'b0;
  end

  // Tracking state, threshold count and last handed descriptor
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_reg   <= ST_IDLE;
      fcnt_reg    <= {THR_W{1'b0}};
      last_st_reg <= 4'h0;
      last_fl_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      fcnt_reg  <= fcnt_next;
      if (handed)
      begin
        last_st_reg <= status_reg;
        last_fl_reg <= fl_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending breakpoints: a new event in the consuming cycle survives
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      burst_pend_reg <= 1'b0;
      svc_pend_reg   <= 1'b0;
    end
    else
    begin
      if (i_burst_evt)
        burst_pend_reg <= 1'b1;
      else if (emit && norm_end && !fault_now)
        burst_pend_reg <= 1'b0;
      if (svc_evt)
        svc_pend_reg <= 1'b1;
      else if (emit && norm_end && !fault_now)
        svc_pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky fault; only a reset truly recovers, so the flag keeps
  // marking every descriptor until software clears it
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      fault_reg <= 1'b0;
    else if (i_hw_fault || bad_state || (accept && cause_bad))
      fault_reg <= 1'b1;
    else if (wr_stb && i_paddr == `RSE_OFF_STAT &&
             i_pwdata[`RSE_STAT_FAULT])
      fault_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctrl_reg   <= `RSE_CTRL_RST;
      thresh_reg <= `RSE_THRESH_RST;
    end
    else if (wr_stb)
    begin
      if (i_paddr == `RSE_OFF_CTRL)
        ctrl_reg <= i_pwdata[2:0];
      if (i_paddr == `RSE_OFF_THRESH)
        thresh_reg <= i_pwdata[THR_W-1:0];
    end
  end

  // Decode: word-aligned only
  assign hit = (i_paddr == `RSE_OFF_CTRL) ||
               (i_paddr == `RSE_OFF_THRESH) ||
               (i_paddr == `RSE_OFF_STAT) ||
               ((i_paddr >= `RSE_OFF_CNT_BASE) &&
                (i_paddr <= `RSE_OFF_CNT_LAST) &&
                (i_paddr[1:0] == 2'b00));

  // Read mux
  always @*
  begin
    rdata = 32'h00000000;
    case (i_paddr)
      `RSE_OFF_CTRL:   rdata[2:0] = ctrl_reg;
      `RSE_OFF_THRESH: rdata[THR_W-1:0] = thresh_reg;
      `RSE_OFF_STAT:
      begin
        rdata[3:0]              = last_st_reg;
        rdata[5:4]              = last_fl_reg;
        rdata[`RSE_STAT_FAULT]  = fault_reg;
        rdata[13:12]            = state_reg;
        rdata[16]               = dvalid_reg;
      end
      default:
        if (i_paddr >= `RSE_OFF_CNT_BASE)
          rdata[CNT_W-1:0] = cnt[i_paddr[3:2]];
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // APB front end
  rse_apb_slave u_apb
  (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_psel    (i_psel),
    .i_penable (i_penable),
    .i_pwrite  (i_pwrite),
    .i_paddr   (i_paddr),
    .o_prdata  (o_prdata),
    .o_pready  (o_pready),
    .o_pslverr (o_pslverr),
    .i_hit     (hit),
    .i_rdata   (rdata),
    .o_wr_stb  (wr_stb)
  );

  ////////////////////////////////////////////////////////////////////////
  // One counter per status class (code bits 3:2); any write to a
  // counter word clears all four, so software reads a clean snapshot
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_cnt
      rse_evt_counter #(.W(CNT_W)) u_cnt
      (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_inc    (handed && (status_reg[3:2] == g)),
        .i_clr    (wr_stb && (i_paddr >= `RSE_OFF_CNT_BASE)),
        .o_count  (cnt[g])
      );
    end
  endgenerate

  // Outputs from the descriptor slot
  assign o_desc_valid  = dvalid_reg;
  assign o_desc_status = status_reg;
  assign o_desc_fl     = fl_reg;

endmodule

/* hw/rse_consts.vh */
// Constants of the receive descriptor status encoder.
// Assumes inclusion by bare name from the encoder design file of the block.
//
// Behaviour
// - Page cross at last queue slot: 0000, discard
// - Never write 0000 into a middle part
// - 0001: page filled, first or middle only
// - 0010: last data unit of the header
// - 0011: page cross together with header end
// - 0100: normal end, no breakpoint
// - 0101: normal end after burst boundary
// - 0110: normal end reaching copied-frame threshold
// - 0111: normal end after service opportunity event
// - 1000: no data space, sort mode off
// - 1001: no header space, sort mode on
// - 1010: header copied, no info copied
// - 1011: header copied, info space ran out
// - 1100: indicate FIFO overrun during copy
// - 1101: bad length or bad check sequence
// - 1110: parity error, only with flow bit
// - 1111: internal receive fault, software resets
// - Tag 10 first, 00 middle, 01 last, 11 only
`ifndef RSE_CONSTS_VH
`define RSE_CONSTS_VH

// Register byte offsets
`define RSE_OFF_CTRL      8'h00
`define RSE_OFF_THRESH    8'h04
`define RSE_OFF_STAT      8'h08
`define RSE_OFF_CNT_BASE  8'h10
`define RSE_OFF_CNT_LAST  8'h1C

// Control fields
`define RSE_CTRL_EN       0
`define RSE_CTRL_SORT     1
`define RSE_CTRL_FLOW     2
`define RSE_CTRL_RST      3'h0

// Status register fields and threshold reset value
`define RSE_STAT_FAULT    8
`define RSE_THRESH_RST    8'h00

// Status codes of the indicate status field
`define RSE_IS_LAST_PC    4'h0
`define RSE_IS_PC         4'h1
`define RSE_IS_HDR        4'h2
`define RSE_IS_PC_HDR     4'h3
`define RSE_IS_NORM       4'h4
`define RSE_IS_BURST      4'h5
`define RSE_IS_THRESH     4'h6
`define RSE_IS_SVC        4'h7
`define RSE_IS_NO_DATA    4'h8
`define RSE_IS_NO_HDR     4'h9
`define RSE_IS_NO_INFO    4'hA
`define RSE_IS_PART_INFO  4'hB
`define RSE_IS_OVERRUN    4'hC
`define RSE_IS_BAD_FRAME  4'hD
`define RSE_IS_PARITY     4'hE
`define RSE_IS_INTERNAL   4'hF

// First/last tags
`define RSE_FL_FIRST      2'h2
`define RSE_FL_MIDDLE     2'h0
`define RSE_FL_LAST       2'h1
`define RSE_FL_ONLY       2'h3

`endif

/* hw/rse_evt_counter.v */
// Event counter for one descriptor class.
// Assumes a one-cycle increment pulse and a synchronous clear.
`timescale 1ns/10ps
module rse_evt_counter
#(
  parameter W = 16
)
(
  // Clock and reset
  input  wire         i_clk,
  input  wire         i_arst_n,
  // Control
  input  wire         i_inc,
  input  wire         i_clr,
  // Count
  output wire [W-1:0] o_count
);

  reg [W-1:0] cnt_reg;  // Running count, wraps

  ////////////////////////////////////////////////////////////////////////
  // Clear wins, so a clear always leaves a known zero
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cnt_reg <= {W{1'b0}};
    else if (i_clr)
      cnt_reg <= {W{1'b0}};
    else if (i_inc)
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
  end

  assign o_count = cnt_reg;

endmodule

/* hw/rse_apb_slave.v */
// APB slave front end: one wait state, registered read data.
// Assumes the register file supplies read data for the decoded index.
`timescale 1ns/10ps
module rse_apb_slave
(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_arst_n,
  // APB
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  output wire [31:0] o_prdata,
  output wire        o_pready,
  output wire        o_pslverr,
  // Register file side
  input  wire        i_hit,
  input  wire [31:0] i_rdata,
  output wire        o_wr_stb
);

  reg        ack_reg;     // Second access cycle
  reg [31:0] rdata_reg;   // Read data held for the master
  wire       first_acc;   // First access cycle

  assign first_acc = i_psel & i_penable & ~ack_reg;

  ////////////////////////////////////////////////////////////////////////
  // Wait state gives time to register read data from the mux
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= first_acc;
      if (first_acc)
        rdata_reg <= (i_hit && !i_pwrite) ? i_rdata : 32'h00000000;
    end
  end

  assign o_pready  = ack_reg;
  assign o_pslverr = ack_reg & ~i_hit;  // Unmapped address
  assign o_prdata  = rdata_reg;
  assign o_wr_stb  = ack_reg & i_psel & i_penable & i_pwrite & i_hit;

endmodule

/* tb/rse_status_encoder_props.sv */
// Port checks for the descriptor status encoder.
// Assumes one clock domain and an active low asynchronous reset.
`timescale 1ns/10ps
module rse_status_encoder_props
(
  // Clock and reset
  input wire       i_clk,
  input wire       i_arst_n,
  // APB
  input wire       i_psel,
  input wire       i_penable,
  input wire       o_pready,
  input wire       o_pslverr,
  // Units
  input wire       i_unit_valid,
  input wire       o_unit_ready,
  input wire       i_frame_end,
  input wire       i_page_cross,
  input wire       i_header_end,
  input wire       i_queue_last,
  input wire       i_fifo_overrun,
  input wire       i_bad_frame,
  input wire       i_hw_fault,
  // Descriptor write
  input wire       o_desc_valid,
  input wire       i_desc_ready,
  input wire [3:0] o_desc_status,
  input wire [1:0] o_desc_fl
);
  ////////////////////////////////////////////////////////////////
  // Unit taken at this edge; a discarded unit leaves no descriptor
  wire acc = i_unit_valid && o_unit_ready;
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  a_desc_hold: assert property (
    o_desc_valid && !i_desc_ready |=> o_desc_valid &&
    $stable(o_desc_status) && $stable(o_desc_fl))
    else $error("descriptor changed before accept");
  a_ready_slot: assert property (
    o_unit_ready |-> !o_desc_valid || i_desc_ready)
    else $error("unit taken with slot full");
  a_end_tag: assert property (
    o_desc_valid && (o_desc_status[3:2] != 2'h0 ||
    o_desc_status == 4'h0) |-> o_desc_fl[0])
    else $error("chain end without last tag");
  a_mid_tag: assert property (
    o_desc_valid && o_desc_status inside {4'h1, 4'h2, 4'h3}
    |-> !o_desc_fl[0])
    else $error("non-end code with last tag");
  a_last_slot: assert property (
    acc && i_page_cross && i_queue_last && !i_frame_end |=>
    !o_desc_valid || o_desc_status inside {4'h0, 4'hF})
    else $error("last slot code wrong");
  a_pc_hdr: assert property (
    acc && i_page_cross && i_header_end && !i_queue_last &&
    !i_frame_end |=> !o_desc_valid ||
    o_desc_status inside {4'h3, 4'hF})
    else $error("page cross header code wrong");
  a_overrun_code: assert property (
    acc && i_frame_end && i_fifo_overrun |=>
    !o_desc_valid || o_desc_status[3:2] == 2'h3)
    else $error("overrun code wrong");
  a_bad_code: assert property (
    acc && i_frame_end && i_bad_frame |=>
    !o_desc_valid || o_desc_status inside {[4'hD:4'hF]})
    else $error("bad frame code wrong");
  a_fault_code: assert property (
    acc && i_hw_fault |=> !o_desc_valid || o_desc_status == 4'hF)
    else $error("fault code wrong");
  a_apb_wait: assert property (
    i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready)
    else $error("apb wait state wrong");
  a_slverr_ready: assert property (o_pslverr |-> o_pready)
    else $error("slverr without ready");
endmodule
bind rse_status_encoder rse_status_encoder_props
  rse_status_encoder_props_inst (.i_clk, .i_arst_n, .i_psel,
  .i_penable, .o_pready, .o_pslverr, .i_unit_valid, .o_unit_ready,
  .i_frame_end, .i_page_cross, .i_header_end, .i_queue_last,
  .i_fifo_overrun, .i_bad_frame, .i_hw_fault, .o_desc_valid,
  .i_desc_ready, .o_desc_status, .o_desc_fl);

/* tb/rse_host_model.sv */
// Host memory side taking descriptor writes.
// Assumes a register-driven ready and a settable stall per write.
`timescale 1ns/10ps
module rse_host_model
(
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_arst_n,
  // Control
  input  wire [3:0] i_stall,
  // Descriptor write
  input  wire       i_valid,
  input  wire [3:0] i_status,
  input  wire [1:0] i_fl,
  output reg        o_ready,
  // What memory holds
  output reg  [3:0] o_status,
  output reg  [1:0] o_fl,
  output reg  [7:0] o_count,
  output reg  [7:0] o_drop
);
  reg [3:0] wait_reg;  // Cycles left before ready again
  ////////////////////////////////////////////////////////////////
  // One write stores one status and tag; stall follows it
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_ready  <= 1'b0;
      o_status <= 4'h0;
      o_fl     <= 2'h0;
      o_count  <= 8'h00;
      o_drop   <= 8'h00;
      wait_reg <= 4'h0;
    end
    else if (i_valid && o_ready)
    begin
      o_status <= i_status;
      o_fl     <= i_fl;
      o_count  <= o_count + 8'h01;
      // Error frames are stored like others and also counted as drops
      if (i_status[3:2] == 2'h3)
        o_drop <= o_drop + 8'h01;
      o_ready  <= (i_stall == 4'h0);
      wait_reg <= i_stall;
    end
    else if (wait_reg != 4'h0)
    begin
      wait_reg <= wait_reg - 4'h1;
      o_ready  <= (wait_reg == 4'h1);
    end
    else
      o_ready <= 1'b1;
  end
endmodule

/* tb/test_receive_descriptor_status_encoder.sv */
// Bench for the descriptor status encoder.
// Assumes the checker is bound and the host model is compiled.
`timescale 1ns/10ps
module test_receive_descriptor_status_encoder;
  reg         i_clk, i_arst_n, i_psel, i_penable, i_pwrite;
  reg  [7:0]  i_paddr;
  reg  [31:0] i_pwdata, q;
  reg         i_unit_valid, e;
  reg  [11:0] f;      // Unit flags, frame end at the top
  reg  [4:0]  ev;     // Breakpoint pulses, burst at bit 0
  reg  [3:0]  stall;  // Host wait per write
  wire [31:0] o_prdata;
  wire        o_pready, o_pslverr, o_unit_ready, o_desc_valid, rdy;
  wire [3:0]  o_desc_status, h_status;
  wire [1:0]  o_desc_fl, h_fl;
  wire [7:0]  h_count, h_drop;
  integer     errors, compares, drops, i;
  rse_status_encoder rse_status_encoder_inst (.i_clk, .i_arst_n,
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_unit_valid, .o_unit_ready,
    .i_frame_end(f[11]), .i_page_cross(f[10]), .i_header_end(f[9]),
    .i_queue_last(f[8]), .i_no_data_space(f[7]),
    .i_no_hdr_space(f[6]), .i_no_info_space(f[5]),
    .i_info_copied(f[4]), .i_fifo_overrun(f[3]), .i_bad_frame(f[2]),
    .i_parity_err(f[1]), .i_hw_fault(f[0]), .i_burst_evt(ev[0]),
    .i_token_evt(ev[1]), .i_mac_reset_event(ev[2]),
    .i_mac_frame_evt(ev[3]), .i_ringop_evt(ev[4]), .o_desc_valid,
    .i_desc_ready(rdy), .o_desc_status, .o_desc_fl);
  rse_host_model rse_host_model_inst (.i_clk, .i_arst_n,
    .i_stall(stall), .i_valid(o_desc_valid), .i_status(o_desc_status),
    .i_fl(o_desc_fl), .o_ready(rdy), .o_status(h_status),
    .o_fl(h_fl), .o_count(h_count), .o_drop(h_drop));
  ////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task end_of_test;
  begin
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // Run is under 300 cycles; a hang trips long after
  initial
  begin
    #100000;
    errors = errors + 1;
    end_of_test;
  end
  task chk(input string n, input [31:0] s, input [31:0] x);
  begin
    compares = compares + 1;
    if (s !== x)
    begin
      errors = errors + 1;
      $display("unexpected %s: expected %h seen %h", n, x, s);
    end
  end
  endtask
  // Request held from setup until pready is seen high at a rising edge;
  // an idle edge between calls keeps one assignment per time step
  task apb(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1)
      @(posedge i_clk);
    q = o_prdata;
    e = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  end
  endtask
  // Unit held until ready is seen high at a rising edge
  task send(input [11:0] fv);
  begin
    @(posedge i_clk);
    i_unit_valid <= 1'b1;
    f            <= fv;
    @(posedge i_clk);
    while (o_unit_ready !== 1'b1)
      @(posedge i_clk);
    i_unit_valid <= 1'b0;
  end
  endtask
  task unit(input [11:0] fv, input [3:0] es, input [1:0] ef);
    reg [7:0] n;
  begin
    n = h_count;
    send(fv);
    while (h_count == n)
      @(negedge i_clk);
    chk("status", h_status, es);
    chk("tag", h_fl, ef);
    if (es[3:2] == 2'h3)
      drops = drops + 1;
  end
  endtask
  // Unit of a discarded frame: no descriptor may appear
  task eat(input [11:0] fv);
    reg [7:0] n;
  begin
    n = h_count;
    send(fv);
    repeat (4) @(negedge i_clk);
    chk("count", h_count, n);
  end
  endtask
  task pulse(input [4:0] v);
  begin
    @(posedge i_clk);
    ev <= v;
    @(posedge i_clk);
    ev <= 5'h00;
  end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    {i_arst_n, i_psel, i_penable, i_pwrite, i_unit_valid} = 5'h00;
    {i_paddr, i_pwdata, f, ev, stall} = 61'h0;
    {errors, compares, drops} = 0;
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    apb(0, 8'h08, 0);
    chk("stat", q, 0);
    apb(0, 8'h40, 0);
    chk("slverr", e, 1);
    chk("rdata", q, 0);
    apb(1, 8'h00, 1);
    apb(1, 8'h04, 2);
    apb(0, 8'h04, 0);
    chk("thresh", q, 2);
    for (i = 0; i < 4; i = i + 1)
      unit(12'h800, (i % 2) ? 4'h6 : 4'h4, 2'h3);
    $display("done threshold");
    // Second reset in mid-run
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    apb(1, 8'h00, 1);
    unit(12'h800, 4'h4, 2'h3);
    unit(12'h804, 4'hD, 2'h3);
    unit(12'h808, 4'hC, 2'h3);
    unit(12'h80C, 4'hD, 2'h3);
    unit(12'h880, 4'h8, 2'h3);
    unit(12'h802, 4'h4, 2'h3);
    pulse(5'h01);
    unit(12'h800, 4'h5, 2'h3);
    for (i = 1; i < 5; i = i + 1)
    begin
      pulse(5'h01 << i);
      unit(12'h800, 4'h7, 2'h3);
    end
    unit(12'h800, 4'h4, 2'h3);
    $display("done codes");
    stall = 4'h3;
    unit(12'h400, 4'h1, 2'h2);
    unit(12'h200, 4'h2, 2'h0);
    unit(12'h600, 4'h3, 2'h0);
    unit(12'h800, 4'h4, 2'h1);
    unit(12'h400, 4'h1, 2'h2);
    unit(12'h500, 4'h0, 2'h1);
    eat(12'h200);
    eat(12'h800);
    // Five class 0 descriptors (codes 0 to 3) handed since the second reset
    apb(0, 8'h10, 0);
    chk("count0", q, 5);
    apb(1, 8'h1C, 0);
    apb(0, 8'h10, 0);
    chk("count0", q, 0);
    $display("done parts");
    apb(1, 8'h00, 3);
    unit(12'h840, 4'h9, 2'h3);
    unit(12'h820, 4'hA, 2'h3);
    unit(12'h830, 4'hB, 2'h3);
    apb(1, 8'h00, 5);
    unit(12'h802, 4'hE, 2'h3);
    $display("done sort");
    unit(12'h801, 4'hF, 2'h3);
    unit(12'h800, 4'hF, 2'h3);
    apb(0, 8'h08, 0);
    chk("fault", q[8], 1);
    apb(1, 8'h08, 32'h100);
    apb(0, 8'h08, 0);
    chk("fault", q[8], 0);
    unit(12'h800, 4'h4, 2'h3);
    chk("drops", h_drop, drops);
    $display("done fault");
    end_of_test;
  end
endmodule
